// file: shared/sok_defines.vh
// constants for the skip-on-overflow execution block
`ifndef SOK_DEFINES_VH
`define SOK_DEFINES_VH

// ------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------------
`define SOK_CTRL_OFS      8'h00
`define SOK_STATUS_OFS    8'h04
`define SOK_PC_OFS        8'h08
`define SOK_MAR_OFS       8'h0c

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define SOK_CTRL_LOOP_BIT    0
`define SOK_ST_OVF_BIT       0
`define SOK_ST_CARRY_BIT     1
`define SOK_ST_INTC_BIT      2
`define SOK_ST_SKIP_BIT      3
`define SOK_ST_SKIPSEEN_BIT  4
`define SOK_WORD_CLF_BIT     9
`define SOK_WORD_SENSE_BIT   6
`define SOK_WORD_GRP_HI      8
`define SOK_WORD_GRP_LO      7
`define SOK_WORD_SEL_HI      5

// ------------------------------------------------------------------
// decode values
// ------------------------------------------------------------------
`define SOK_GRP_FLAG      2'h1
`define SOK_SEL_OVF       6'h01
`define SOK_WORD_SOS      16'h84c1
`define SOK_WORD_SOC      16'h8481

// ------------------------------------------------------------------
// machine cycle slots
// ------------------------------------------------------------------
`define SOK_T0            3'h0
`define SOK_T3            3'h3
`define SOK_T4            3'h4
`define SOK_T6            3'h6
`define SOK_T7            3'h7

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SOK_CTRL_RST      1'h0
`define SOK_INTC_RST      1'h1
`define SOK_ADDR_RST      15'h0000

`endif

// file: hdl/sok_skip_exec.v
// skip-on-overflow instruction execution with an ahb-lite register slave
//
// Summary of operation
// - skip pulse sets the carry flip-flop at the T4 timing strobe.
// - with carry set, program counter and address register advance by two.
// - carry flip-flop clears at slot T0 of the following cycle.
// - without skip, advance by one in T6/T7, then set phase one.
// - words 102301 and 102201 octal are skip-if-set and skip-if-clear.
// - bit nine of either skip word also performs the clear-flag action.
// - loop test mode suppresses the low-order increment, repeating a word that does not skip.
// - skip pulse from set strobe with overflow, or clear strobe without.
// - at T3, word bits 8..6 and group enable raise the strobes.
// - bit nine raises clear-flag at T4; clears interrupt and overflow.
// - interrupt control flip-flop set again at T7 strobe of that cycle.
`timescale 1ns/1ps
`include "sok_defines.vh"

module sok_skip_exec
(
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [31:0] hrdata,
    input  wire [2:0]  slot,
    input  wire        timing_strobe,
    input  wire        fetch_phase,
    input  wire [15:0] instr_word,
    input  wire        io_group_enable,
    input  wire        overflow_set,
    output reg         skip_if_set_strobe,
    output reg         skip_if_clear_strobe,
    output reg         skip_pulse,
    output reg         clear_flag_pulse,
    output reg         carry_ff_output,
    output reg         overflow_ff,
    output reg         interrupt_ctrl_ff,
    output reg         low_order_increment_signal,
    output reg         counter_readout_strobe,
    output reg         adder_function_select,
    output reg         counter_store_strobes,
    output reg         address_store_strobes,
    output reg         next_phase_set,
    output reg  [14:0] program_counter,
    output reg  [14:0] memory_address
);

    // ------------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------------
    reg        dphase_reg;
    reg        dwrite_reg;
    reg [7:0]  daddr_reg;
    reg        loop_mode_reg;
    reg        clf_seen_reg;
    reg        skip_seen_reg;

    wire       addr_take;
    wire       wr_ctrl;
    wire       wr_status;
    wire       wr_pc;
    wire       wr_mar;

    // ------------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------------
    wire       grp_ok;
    wire       sel_device;
    wire       strobe_win;
    wire       sfs_next;
    wire       sfc_next;
    wire       skip_next;
    wire       clf_next;
    wire       t4_edge;
    wire       t7_edge;
    wire       step_win;
    wire [14:0] inc_one;
    wire [14:0] inc_carry;
    wire [14:0] step_next;

    // address phase accepted when selected, nonseq/seq and bus ready
    assign addr_take = hsel & htrans[1] & hready;
    assign wr_ctrl   = dphase_reg & dwrite_reg &
                       (daddr_reg == `SOK_CTRL_OFS);
    assign wr_status = dphase_reg & dwrite_reg &
                       (daddr_reg == `SOK_STATUS_OFS);
    assign wr_pc     = dphase_reg & dwrite_reg &
                       (daddr_reg == `SOK_PC_OFS);
    assign wr_mar    = dphase_reg & dwrite_reg &
                       (daddr_reg == `SOK_MAR_OFS);

    // selected device: the overflow select code on the low word bits
    assign sel_device = io_group_enable &
        (instr_word[`SOK_WORD_SEL_HI:0] == `SOK_SEL_OVF);
    assign grp_ok = io_group_enable &
        (instr_word[`SOK_WORD_GRP_HI:`SOK_WORD_GRP_LO] == `SOK_GRP_FLAG);
    // strobes stand through T3 and T4 so the T4 strobe still sees them
    assign strobe_win = fetch_phase &
        ((slot == `SOK_T3) | (slot == `SOK_T4));
    assign sfs_next = strobe_win & grp_ok & instr_word[`SOK_WORD_SENSE_BIT];
    assign sfc_next = strobe_win & grp_ok &
        ~instr_word[`SOK_WORD_SENSE_BIT];
    assign skip_next = sel_device &
        ((sfs_next & overflow_ff) | (sfc_next & ~overflow_ff));
    assign clf_next = fetch_phase & io_group_enable & (slot == `SOK_T4) &
        instr_word[`SOK_WORD_CLF_BIT];

    assign t4_edge  = fetch_phase & (slot == `SOK_T4) & timing_strobe;
    assign t7_edge  = fetch_phase & (slot == `SOK_T7) & timing_strobe;
    assign step_win = fetch_phase &
        ((slot == `SOK_T6) | (slot == `SOK_T7));

    assign inc_one   = loop_mode_reg ? 15'h0000 : 15'h0001;
    assign inc_carry = carry_ff_output ? 15'h0001 : 15'h0000;
    assign step_next = program_counter + inc_one + inc_carry;

    // ------------------------------------------------------------------
    // ahb-lite slave, one wait state on every transfer
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dphase_reg <= 1'b0;
            dwrite_reg <= 1'b0;
            daddr_reg  <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0000_0000;
        end
        else if (dphase_reg)
        begin
            // data phase: finish and release the bus
            dphase_reg <= 1'b0;
            hreadyout  <= 1'b1;
            if (dwrite_reg)
                hrdata <= 32'h0000_0000;
            else if (daddr_reg == `SOK_CTRL_OFS)
                hrdata <= {31'h0000_0000, loop_mode_reg};
            else if (daddr_reg == `SOK_STATUS_OFS)
                hrdata <= {27'h000_0000, skip_seen_reg, skip_pulse,
                           interrupt_ctrl_ff, carry_ff_output, overflow_ff};
            else if (daddr_reg == `SOK_PC_OFS)
                hrdata <= {17'h0_0000, program_counter};
            else if (daddr_reg == `SOK_MAR_OFS)
                hrdata <= {17'h0_0000, memory_address};
            else
                hrdata <= 32'h0000_0000;   // unmapped reads as zero
        end
        else if (addr_take)
        begin
            dphase_reg <= 1'b1;
            dwrite_reg <= hwrite;
            daddr_reg  <= {haddr[7:2], 2'b00};
            hreadyout  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            loop_mode_reg <= `SOK_CTRL_RST;
        else if (wr_ctrl)
            loop_mode_reg <= hwdata[`SOK_CTRL_LOOP_BIT];
    end

    // ------------------------------------------------------------------
    // decode strobes, registered onto the outputs
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            skip_if_set_strobe   <= 1'b0;
            skip_if_clear_strobe <= 1'b0;
            skip_pulse           <= 1'b0;
            clear_flag_pulse     <= 1'b0;
        end
        else
        begin
            skip_if_set_strobe   <= sfs_next;
            skip_if_clear_strobe <= sfc_next;
            skip_pulse           <= skip_next;
            clear_flag_pulse     <= clf_next;
        end
    end

    // ------------------------------------------------------------------
    // carry flip-flop
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            carry_ff_output <= 1'b0;
        else if (t4_edge & skip_next)
            carry_ff_output <= 1'b1;
        else if (slot == `SOK_T0)
            carry_ff_output <= 1'b0;
    end

    // sticky record of a skip, cleared by writing one to its status bit
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            skip_seen_reg <= 1'b0;
        else if (t4_edge & skip_next)
            skip_seen_reg <= 1'b1;   // a new skip wins over the clear
        else if (wr_status & hwdata[`SOK_ST_SKIPSEEN_BIT])
            skip_seen_reg <= 1'b0;
    end

    // ------------------------------------------------------------------
    // overflow flip-flop: set by the arithmetic or by software
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            overflow_ff <= 1'b0;
        else if (overflow_set | (wr_status & hwdata[`SOK_ST_OVF_BIT]))
            overflow_ff <= 1'b1;
        else if (t4_edge & clf_next & sel_device)
            overflow_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // interrupt control flip-flop
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            interrupt_ctrl_ff <= `SOK_INTC_RST;
            clf_seen_reg      <= 1'b0;
        end
        else if (t7_edge & clf_seen_reg)
        begin
            interrupt_ctrl_ff <= 1'b1;
            clf_seen_reg      <= 1'b0;
        end
        else if (clf_next)
        begin
            interrupt_ctrl_ff <= 1'b0;
            clf_seen_reg      <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // counter strobes during T6 and T7
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            counter_readout_strobe     <= 1'b0;
            low_order_increment_signal <= 1'b0;
            adder_function_select      <= 1'b0;
            counter_store_strobes      <= 1'b0;
            address_store_strobes      <= 1'b0;
            next_phase_set             <= 1'b0;
        end
        else
        begin
            counter_readout_strobe     <= step_win;
            low_order_increment_signal <= step_win & ~loop_mode_reg;
            adder_function_select      <= step_win;
            counter_store_strobes      <= step_win;
            address_store_strobes      <= step_win;
            next_phase_set             <= t7_edge;
        end
    end

    // ------------------------------------------------------------------
    // program counter and memory address register
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            program_counter <= `SOK_ADDR_RST;
            memory_address  <= `SOK_ADDR_RST;
        end
        else
        begin
            if (wr_pc)
                program_counter <= hwdata[14:0];
            else if (t7_edge)
                program_counter <= step_next;

            if (wr_mar)
                memory_address <= hwdata[14:0];
            else if (t7_edge)
                memory_address <= step_next;
        end
    end

endmodule // sok_skip_exec

// file: verif/sok_timing_gen.sv
// timing generator model driving the eight-slot machine cycle
`timescale 1ns/1ps
module sok_timing_gen
(
    input  logic       hclk,
    input  logic       hresetn,
    output logic [2:0] slot,
    output logic       timing_strobe,
    output logic       fetch_phase
);
    logic [3:0] phase_cnt_reg;

    // two clocks per slot, the timing strobe falls in the second one
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            phase_cnt_reg <= 4'h0;
        else
            phase_cnt_reg <= phase_cnt_reg + 4'h1;
    end

    assign slot          = phase_cnt_reg[3:1];
    assign timing_strobe = phase_cnt_reg[0];
    assign fetch_phase   = 1'b1; // every cycle runs as the fetch phase
endmodule // sok_timing_gen

// file: verif/sok_skip_exec_asserts.sv
// port checker for the skip-on-overflow execution block
`timescale 1ns/1ps
module sok_skip_exec_asserts
(
    input logic        hclk,
    input logic        hresetn,
    input logic        hreadyout,
    input logic [2:0]  slot,
    input logic        timing_strobe,
    input logic        fetch_phase,
    input logic [15:0] instr_word,
    input logic        io_group_enable,
    input logic        skip_if_set_strobe,
    input logic        skip_if_clear_strobe,
    input logic        skip_pulse,
    input logic        clear_flag_pulse,
    input logic        carry_ff_output,
    input logic        overflow_ff,
    input logic        interrupt_ctrl_ff,
    input logic        low_order_increment_signal,
    input logic        counter_readout_strobe,
    input logic        adder_function_select,
    input logic        counter_store_strobes,
    input logic        address_store_strobes,
    input logic        next_phase_set,
    input logic [14:0] program_counter,
    input logic [14:0] memory_address
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    strobe_decode_a: assert property (fetch_phase && io_group_enable &&
        slot == 3'h3 && instr_word[8:6] == 3'h3
        |=> skip_if_set_strobe && !skip_if_clear_strobe)
        else $error("set strobe not raised at slot three");
    skip_source_a: assert property (skip_pulse |->
        ($past(overflow_ff) ? skip_if_set_strobe : skip_if_clear_strobe))
        else $error("skip pulse without matching strobe");
    carry_set_a: assert property (fetch_phase && slot == 3'h4 &&
        timing_strobe && skip_pulse |=> carry_ff_output)
        else $error("carry not set by skip at slot four");
    carry_cause_a: assert property ($rose(carry_ff_output) |->
        $past(slot) == 3'h4 && $past(timing_strobe) && $past(skip_pulse))
        else $error("carry set outside the slot four strobe");
    carry_clear_a: assert property (slot == 3'h0 |=> !carry_ff_output)
        else $error("carry not cleared at slot zero");
    pc_step_a: assert property (fetch_phase && slot == 3'h7 &&
        timing_strobe && hreadyout |=> program_counter ==
        $past(program_counter) + {14'h0, $past(low_order_increment_signal)}
        + {14'h0, $past(carry_ff_output)} && memory_address == program_counter)
        else $error("counter step wrong");
    step_window_a: assert property (fetch_phase && slot[2:1] == 2'h3
        |=> counter_readout_strobe && adder_function_select &&
        counter_store_strobes && address_store_strobes)
        else $error("step strobes missing in slots six and seven");
    next_phase_a: assert property (fetch_phase && slot == 3'h7 &&
        timing_strobe |=> next_phase_set ##1 !next_phase_set)
        else $error("next phase pulse wrong");
    clear_flag_a: assert property (fetch_phase && io_group_enable &&
        slot == 3'h4 && instr_word[9] |=> clear_flag_pulse && !interrupt_ctrl_ff)
        else $error("clear flag did not clear interrupt control");
    intc_restore_a: assert property (fetch_phase && slot == 3'h7 &&
        timing_strobe |=> interrupt_ctrl_ff)
        else $error("interrupt control not set again");
endmodule // sok_skip_exec_asserts

bind sok_skip_exec sok_skip_exec_asserts sok_skip_exec_asserts_i (.*);

// file: verif/sok_skip_exec_test.sv
// self-checking bench for the skip-on-overflow execution block
`timescale 1ns/1ps
module sok_skip_exec_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, timing_strobe;
    logic fetch_phase, io_group_enable, overflow_set, skip_if_set_strobe;
    logic skip_if_clear_strobe, skip_pulse, clear_flag_pulse, carry_ff_output;
    logic overflow_ff, interrupt_ctrl_ff, low_order_increment_signal;
    logic counter_readout_strobe, adder_function_select, counter_store_strobes;
    logic address_store_strobes, next_phase_set, carry_seen, clf_seen;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, slot;
    logic [31:0] hwdata, hrdata, rd;
    logic [15:0] instr_word;
    logic [14:0] program_counter, memory_address;
    int bad_count, checks_done, cycles;

    sok_skip_exec sok_skip_exec_i (.hready(hreadyout), .*);
    sok_timing_gen sok_timing_gen_i (.*);

    initial
    begin
        hclk = 0;
        forever #2.5 hclk = ~hclk;
    end

    // notes carry and clear-flag activity during one instruction
    always @(posedge hclk)
    begin
        cycles++;
        if (carry_ff_output === 1'b1) carry_seen = 1;
        if (interrupt_ctrl_ff === 1'b0) clf_seen = 1;
        if (cycles == 5000) begin bad_count++; final_report; end
    end

    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        r = hrdata;
    endtask

    // one skip instruction from slot zero to the next phase pulse
    task automatic run_word(input logic [15:0] w, input logic ovf, lp, grp);
        logic sk;
        int n;
        sk = grp & (ovf ? w[6] : !w[6]);
        n = 0;
        instr_word <= w; io_group_enable <= grp;
        do @(posedge hclk); while (slot !== 3'h0 && ++n < 40);
        overflow_set <= ovf;
        @(posedge hclk);
        overflow_set <= 1'b0;
        carry_seen = 0; clf_seen = 0;
        bus(1'b1, 8'h00, {31'h0, lp}, rd);
        bus(1'b1, 8'h08, 32'h200, rd);
        do @(posedge hclk); while (next_phase_set !== 1'b1 && ++n < 80);
        chk(program_counter, 15'h200 + !lp + sk, "program counter");
        chk(memory_address, 15'h200 + !lp + sk, "address register");
        chk(carry_seen, sk, "carry activity");
        chk(clf_seen, w[9] & grp, "clear flag activity");
        chk(overflow_ff, ovf & !(w[9] & grp), "overflow after");
        chk(interrupt_ctrl_ff, 1'b1, "interrupt control back");
    endtask

    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
        hsize = 3'h2; hwdata = 0; instr_word = 0; io_group_enable = 1;
        overflow_set = 0; carry_seen = 0; clf_seen = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        chk(carry_ff_output, 1'b0, "carry in reset");
        chk(interrupt_ctrl_ff, 1'b1, "interrupt in reset");
        bus(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h4, "status reset value");
        // skip-if-set and skip-if-clear with and without overflow
        run_word(16'h84c1, 1'b0, 1'b0, 1'b1);
        run_word(16'h8481, 1'b0, 1'b0, 1'b1);
        run_word(16'h84c1, 1'b1, 1'b0, 1'b1);
        run_word(16'h8481, 1'b1, 1'b0, 1'b1);
        run_word(16'h86c1, 1'b1, 1'b0, 1'b1);
        run_word(16'h8681, 1'b0, 1'b0, 1'b1);
        run_word(16'h84c1, 1'b1, 1'b1, 1'b1);
        run_word(16'h8481, 1'b1, 1'b1, 1'b1);
        run_word(16'h8681, 1'b1, 1'b0, 1'b0);
        bus(1'b0, 8'h00, 32'h0, rd);
        chk(rd, 32'h0, "control read back");
        bus(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        chk(hresp, 1'b0, "bus response");
        final_report;
    end
endmodule // sok_skip_exec_test
